// ---- common/iep_pkg.sv ----
package iep_pkg;
  // ****************************************
  // widths and counts
  // ****************************************
  localparam int NUM_SRC = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LVL_W = 2;
  localparam int SRC_W = 3;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hB8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hB7;
  localparam logic [7:0] ADDR_BITOP = 8'hB0;
  localparam logic [7:0] ADDR_STATUS = 8'hB1;
  localparam logic [7:0] ADDR_MASK = 8'hB2;
  localparam logic [7:0] ADDR_ACTIVE = 8'hB3;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int GLOBAL_EN_BIT = 7;
  localparam int BITOP_SEL_LSB = 0;
  localparam int BITOP_REG_BIT = 3;
  localparam int BITOP_VAL_BIT = 7;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [6:0] SRC_MASK = 7'h7F;
  // status bits: 0 grant issued, 1 preempt grant, 2 grant refused by nesting
  localparam int EV_GRANT = 0;
  localparam int EV_PREEMPT = 1;
  localparam int EV_BLOCKED = 2;
  localparam int NUM_EV = 3;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [3:0] ACTIVE_NONE = 4'h0;
  // source indices, which are also the enable register bit positions
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_TMR1 = 3'h3;
  localparam logic [2:0] SRC_SER = 3'h4;
  localparam logic [2:0] SRC_TMR2 = 3'h5;
  localparam logic [2:0] SRC_CNTARR = 3'h6;
endpackage : iep_pkg

// ---- logic/iep_arbiter.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// combinational pick of the best request
// ****************************************
module iep_arbiter #(
  parameter int N = iep_pkg::NUM_SRC
) (
  input wire logic [N-1:0] i_req,
  input wire logic [N-1:0] i_prio_high,
  input wire logic [N-1:0] i_prio_low,
  output logic o_any,
  output logic [iep_pkg::SRC_W-1:0] o_src,
  output logic [iep_pkg::LVL_W-1:0] o_lvl
);
  import iep_pkg::*;

  // the source index must be able to name every source
  generate
    if (N < 1 || N > (1 << SRC_W)) begin : g_bad_n
      $error("iep_arbiter source count does not fit the index width");
    end
  endgenerate

  logic [LVL_W-1:0] lvl [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lvl
      assign lvl[g] = {i_prio_high[g], i_prio_low[g]};
    end
  endgenerate

  always_comb begin
    o_any = 1'b0;
    o_src = '0;
    o_lvl = '0;
    // lowest index scans first; only a strictly higher level displaces it
    for (int k = 0; k < N; k++) begin
      if (i_req[k] && (!o_any || (lvl[k] > o_lvl))) begin
        o_any = 1'b1;
        o_src = SRC_W'(k);
        o_lvl = lvl[k];
      end
    end
  end
endmodule : iep_arbiter
`default_nettype wire

// ---- logic/iep_controller.sv ----
`timescale 1ns/10ps
`default_nettype none
module iep_controller #(
  parameter int NSRC = iep_pkg::NUM_SRC
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic [iep_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [iep_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [iep_pkg::DATA_W-1:0] O_RDATA,
  input wire logic [iep_pkg::NUM_SRC-1:0] I_SRC_REQ,
  input wire logic I_ACK,
  input wire logic I_RETI,
  output logic O_CORE_REQ,
  output logic [iep_pkg::SRC_W-1:0] O_CORE_SRC,
  output logic [iep_pkg::LVL_W-1:0] O_CORE_LVL,
  output logic O_IRQ
);
  import iep_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (NSRC != NUM_SRC) begin : g_bad_nsrc
      $error("iep_controller serves exactly seven sources");
    end
  endgenerate

  // ****************************************
  // state
  // ****************************************
  logic [7:0] enable_reg, enable_next;
  logic [NUM_SRC-1:0] prio_low_reg, prio_low_next;
  logic [NUM_SRC-1:0] prio_high_reg, prio_high_next;
  logic [NUM_EV-1:0] status_reg, status_next;
  logic [NUM_EV-1:0] mask_reg, mask_next;
  // one bit per level currently in service (nesting stack)
  logic [3:0] active_reg, active_next;
  logic [7:0] rdata_reg, rdata_next;
  logic core_req_reg, core_req_next;
  logic [SRC_W-1:0] core_src_reg, core_src_next;
  logic [LVL_W-1:0] core_lvl_reg, core_lvl_next;
  logic irq_reg, irq_next;

  // ****************************************
  // gating and arbitration
  // ****************************************
  logic [NUM_SRC-1:0] gated_req;
  logic arb_any;
  logic [SRC_W-1:0] arb_src;
  logic [LVL_W-1:0] arb_lvl;
  logic [LVL_W-1:0] run_lvl;
  logic running;
  logic may_preempt;

  // per-source enable bits sit at the source index; bit 7 gates them all
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_gate
      assign gated_req[g] = I_SRC_REQ[g] & enable_reg[g]
                            & enable_reg[GLOBAL_EN_BIT];
    end
  endgenerate

  iep_arbiter #(
    .N(NUM_SRC)
  ) u_arb (
    .i_req(gated_req),
    .i_prio_high(prio_high_reg),
    .i_prio_low(prio_low_reg),
    .o_any(arb_any),
    .o_src(arb_src),
    .o_lvl(arb_lvl)
  );

  always_comb begin
    running = |active_reg;
    run_lvl = '0;
    for (int k = 0; k < (1 << LVL_W); k++) begin
      if (active_reg[k]) begin
        run_lvl = LVL_W'(k);
      end
    end
  end

  // level 3 in service: nothing is strictly above it, so nothing preempts
  assign may_preempt = !running || (arb_lvl > run_lvl);

  // ****************************************
  // grant and nesting
  // ****************************************
  logic grant_take;
  assign grant_take = core_req_reg && I_ACK;

  always_comb begin
    core_req_next = core_req_reg;
    core_src_next = core_src_reg;
    core_lvl_next = core_lvl_reg;
    active_next = active_reg;
    if (I_RETI) begin
      for (int k = (1 << LVL_W) - 1; k >= 0; k--) begin
        if (active_reg[k] && (LVL_W'(k) == run_lvl)) begin
          active_next[k] = 1'b0;
        end
      end
    end
    if (grant_take) begin
      active_next[core_lvl_reg] = 1'b1;
      core_req_next = 1'b0;
    end else begin
      // request offer follows the arbiter while the core has not taken it
      core_req_next = arb_any && may_preempt && !I_RETI;
      core_src_next = arb_src;
      core_lvl_next = arb_lvl;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  logic bitop_wr;
  logic [2:0] bitop_sel;
  logic bitop_val;
  assign bitop_wr = I_WR && (I_ADDR == ADDR_BITOP);
  assign bitop_sel = I_WDATA[BITOP_SEL_LSB +: SRC_W];
  assign bitop_val = I_WDATA[BITOP_VAL_BIT];

  always_comb begin
    enable_next = enable_reg;
    prio_low_next = prio_low_reg;
    prio_high_next = prio_high_reg;
    mask_next = mask_reg;
    if (I_WR) begin
      case (I_ADDR)
        ADDR_ENABLE: enable_next = I_WDATA;
        ADDR_PRIO_LOW: prio_low_next = I_WDATA[NUM_SRC-1:0];
        ADDR_PRIO_HIGH: prio_high_next = I_WDATA[NUM_SRC-1:0];
        ADDR_MASK: mask_next = I_WDATA[NUM_EV-1:0];
        default: ;
      endcase
    end
    // single-bit set or clear; bit 3 selects low priority instead of enable
    if (bitop_wr) begin
      if (I_WDATA[BITOP_REG_BIT]) begin
        if (bitop_sel != SRC_W'(NUM_SRC)) begin
          prio_low_next[bitop_sel] = bitop_val;
        end
      end else begin
        enable_next[bitop_sel] = bitop_val;
      end
    end
  end

  always_comb begin
    rdata_next = ZERO8;
    if (I_RD) begin
      case (I_ADDR)
        ADDR_ENABLE: rdata_next = enable_reg;
        ADDR_PRIO_LOW: rdata_next = {1'b0, prio_low_reg};
        ADDR_PRIO_HIGH: rdata_next = {1'b0, prio_high_reg};
        ADDR_STATUS: rdata_next = {5'h00, status_reg};
        ADDR_MASK: rdata_next = {5'h00, mask_reg};
        ADDR_ACTIVE: rdata_next = {4'h0, active_reg};
        default: rdata_next = ZERO8;
      endcase
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] clr;
  assign ev[EV_GRANT] = grant_take;
  assign ev[EV_PREEMPT] = grant_take && running;
  assign ev[EV_BLOCKED] = arb_any && !may_preempt;
  assign clr = (I_WR && (I_ADDR == ADDR_STATUS)) ? I_WDATA[NUM_EV-1:0] : '0;

  always_comb begin
    // set wins over a same-cycle clear
    status_next = (status_reg & ~clr) | ev;
    irq_next = |(status_next & mask_next);
  end

  // ****************************************
  // registers
  // ****************************************
  // ****************************************
  // software-visible configuration
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      enable_reg <= ENABLE_RST;
      prio_low_reg <= PRIO_RST[NUM_SRC-1:0];
      prio_high_reg <= PRIO_RST[NUM_SRC-1:0];
      mask_reg <= '0;
    end else if (I_CE) begin
      enable_reg <= enable_next;
      prio_low_reg <= prio_low_next;
      prio_high_reg <= prio_high_next;
      mask_reg <= mask_next;
    end
  end

  // ****************************************
  // nesting and core offer
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      active_reg <= ACTIVE_NONE;
      core_req_reg <= 1'b0;
      core_src_reg <= '0;
      core_lvl_reg <= '0;
    end else if (I_CE) begin
      active_reg <= active_next;
      core_req_reg <= core_req_next;
      core_src_reg <= core_src_next;
      core_lvl_reg <= core_lvl_next;
    end
  end

  // ****************************************
  // status and interrupt line
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else if (I_CE) begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= ZERO8;
    end else if (I_CE) begin
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_CORE_REQ = core_req_reg;
  assign O_CORE_SRC = core_src_reg;
  assign O_CORE_LVL = core_lvl_reg;
  assign O_IRQ = irq_reg;
endmodule : iep_controller
`default_nettype wire

// ---- verification/iep_controller_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module iep_controller_properties (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [iep_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [iep_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [iep_pkg::DATA_W-1:0] O_RDATA,
  input wire logic [iep_pkg::NUM_SRC-1:0] I_SRC_REQ,
  input wire logic I_ACK,
  input wire logic I_RETI,
  input wire logic O_CORE_REQ,
  input wire logic [iep_pkg::SRC_W-1:0] O_CORE_SRC,
  input wire logic [iep_pkg::LVL_W-1:0] O_CORE_LVL,
  input wire logic O_IRQ
);
  import iep_pkg::*;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // a top level service runs from its accepted offer until the next return
  logic top_busy;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      top_busy <= 1'b0;
    end else if (I_RETI) begin
      top_busy <= 1'b0;
    end else if (O_CORE_REQ && I_ACK && O_CORE_LVL == LVL_TOP) begin
      top_busy <= 1'b1;
    end
  end
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == ZERO8)
    else $error("read data not idle");
  a_unmapped_zero: assert property (I_RD && I_ADDR == 8'hFF |=> O_RDATA == ZERO8)
    else $error("unmapped read not zero");
  a_high_bit7: assert property (I_RD && I_ADDR == ADDR_PRIO_HIGH |=> !O_RDATA[7])
    else $error("reserved bit read high");
  a_ack_drop: assert property (O_CORE_REQ && I_ACK |=> !O_CORE_REQ)
    else $error("offer held after ack");
  a_top_hold: assert property (top_busy |-> !O_CORE_REQ)
    else $error("top level service preempted");
  a_no_src_idle: assert property ($past(I_SRC_REQ) == 7'h00 |-> !O_CORE_REQ)
    else $error("offer without request");
  a_single_pick: assert property ($onehot($past(I_SRC_REQ)) && O_CORE_REQ
    |-> $past(I_SRC_REQ) == (7'h01 << O_CORE_SRC)) else $error("wrong source offered");
  a_src_range: assert property (O_CORE_REQ |-> O_CORE_SRC != 3'h7
    && (($past(I_SRC_REQ) >> O_CORE_SRC) & 7'h01) == 7'h01)
    else $error("offered source out of range or not requesting");
  a_mask_quiet: assert property (I_WR && I_ADDR == ADDR_MASK && I_WDATA == ZERO8
    |=> ##1 !O_IRQ) else $error("irq with empty mask");
endmodule : iep_controller_properties
bind iep_controller iep_controller_properties u_props (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_SRC_REQ(I_SRC_REQ), .I_ACK(I_ACK), .I_RETI(I_RETI), .O_CORE_REQ(O_CORE_REQ),
  .O_CORE_SRC(O_CORE_SRC), .O_CORE_LVL(O_CORE_LVL), .O_IRQ(O_IRQ));
`default_nettype wire

// ---- verification/iep_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module iep_core_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_hold,
  input wire logic i_ret,
  output logic o_ack,
  output logic o_reti
);
  // takes an offer one cycle late unless held, never twice in a row
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_reti <= 1'b0;
    end else begin
      o_ack <= i_req && !i_hold && !o_ack;
      o_reti <= i_ret;
    end
  end
endmodule : iep_core_model
`default_nettype wire

// ---- verification/iep_controller_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module iep_controller_tb;
  import iep_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold = 1'b1;
  logic ce = 1'b1;
  logic ret = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [6:0] src = 7'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic creq, irq, ack, reti;
  logic [2:0] csrc;
  logic [1:0] clvl;
  int n_errors = 0;
  int n_compared = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  iep_controller u_dut (.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SRC_REQ(src), .I_ACK(ack),
    .I_RETI(reti), .O_CORE_REQ(creq), .O_CORE_SRC(csrc), .O_CORE_LVL(clvl), .O_IRQ(irq));
  iep_core_model u_core (.i_clk(clk), .i_rst(rst), .i_req(creq), .i_hold(hold),
    .i_ret(ret), .o_ack(ack), .o_reti(reti));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // packs offer flag, level and source as 00_r_ll_sss
  task automatic see(input logic [6:0] r, output logic [7:0] v);
    @(posedge clk);
    src <= r;
    repeat (4) @(posedge clk);
    #1;
    v = {2'b00, creq, clvl, csrc};
  endtask : see
  task automatic s_regs;
    rd_reg(ADDR_ENABLE, d);
    chk(d, ENABLE_RST);
    rd_reg(ADDR_PRIO_LOW, d);
    chk(d, PRIO_RST);
    rd_reg(ADDR_PRIO_HIGH, d);
    chk(d, PRIO_RST);
    wr_reg(ADDR_PRIO_HIGH, 8'hFF);
    rd_reg(ADDR_PRIO_HIGH, d);
    chk(d, 8'h7F);
    wr_reg(8'hFF, 8'h5A);
    rd_reg(8'hFF, d);
    chk(d, ZERO8);
    wr_reg(ADDR_BITOP, 8'h85);
    wr_reg(ADDR_BITOP, 8'h8E);
    rd_reg(ADDR_ENABLE, d);
    chk(d, 8'h20);
    rd_reg(ADDR_PRIO_LOW, d);
    chk(d, 8'h40);
    wr_reg(ADDR_BITOP, 8'h05);
    rd_reg(ADDR_ENABLE, d);
    chk(d, ZERO8);
    wr_reg(ADDR_PRIO_HIGH, ZERO8);
    wr_reg(ADDR_PRIO_LOW, ZERO8);
  endtask : s_regs
  task automatic s_gate;
    wr_reg(ADDR_ENABLE, 8'h7F);
    see(7'h7F, d);
    chk(d, ZERO8);
    wr_reg(ADDR_ENABLE, 8'h80);
    see(7'h7F, d);
    chk(d, ZERO8);
    for (int i = 0; i < NUM_SRC; i++) begin
      wr_reg(ADDR_ENABLE, 8'h80 | (8'h01 << i));
      see(7'h7F, d);
      chk(d, 8'h20 | 8'(i));
    end
  endtask : s_gate
  task automatic s_order;
    wr_reg(ADDR_ENABLE, 8'hFF);
    for (int i = 0; i < NUM_SRC; i++) begin
      see(7'h7F << i, d);
      chk(d, 8'h20 | 8'(i));
    end
    wr_reg(ADDR_PRIO_HIGH, 8'h60);
    wr_reg(ADDR_PRIO_LOW, 8'h50);
    see(7'h7F, d);
    chk(d, 8'h3E);
    see(7'h3F, d);
    chk(d, 8'h35);
    see(7'h1F, d);
    chk(d, 8'h2C);
  endtask : s_order
  task automatic s_nest;
    wr_reg(ADDR_MASK, 8'h03);
    see(7'h01, d);
    chk(d, 8'h20);
    @(posedge clk);
    hold <= 1'b0;
    see(7'h05, d);
    rd_reg(ADDR_ACTIVE, d);
    chk(d, 8'h01);
    see(7'h15, d);
    rd_reg(ADDR_ACTIVE, d);
    chk(d, 8'h03);
    see(7'h55, d);
    see(7'h7F, d);
    rd_reg(ADDR_ACTIVE, d);
    chk(d, 8'h0B);
    rd_reg(ADDR_STATUS, d);
    chk(d, 8'h07);
    chk(8'(irq), 8'h01);
    wr_reg(ADDR_STATUS, 8'h07);
    repeat (2) @(posedge clk);
    #1;
    chk(8'(irq), 8'h00);
    src <= 7'h00;
    repeat (3) begin
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      repeat (2) @(posedge clk);
    end
    rd_reg(ADDR_ACTIVE, d);
    chk(d, ACTIVE_NONE);
    wr_reg(ADDR_MASK, ZERO8);
  endtask : s_nest
  // a write while the clock enable is low must leave the enable register as it was
  task automatic s_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(ADDR_ENABLE, ZERO8);
    ce <= 1'b1;
    rd_reg(ADDR_ENABLE, d);
    chk(d, 8'hFF);
  endtask : s_freeze
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    s_regs;
    s_gate;
    s_order;
    s_nest;
    s_freeze;
    wrap_up;
  end
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
endmodule : iep_controller_tb
`default_nettype wire
